/* File: hw/pcg_pkg.sv */
// Constants and carrier types for the PLL clock generator control block
package pcg_pkg;

   // Wishbone widths
   localparam int unsigned WB_AW = 8;
   localparam int unsigned WB_DW = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTL = 8'h1c;
   localparam logic [7:0] IDX_BW = 8'h1d;
   localparam logic [7:0] IDX_PROG = 8'h1e;

   // Control register fields
   localparam int unsigned CTL_IE = 7;
   localparam int unsigned CTL_FLAG = 6;
   localparam int unsigned CTL_ON = 5;
   localparam int unsigned CTL_SEL = 4;
   localparam logic [3:0] CTL_LOW_RD = 4'hf;

   // Bandwidth register fields
   localparam int unsigned BW_AUTO = 7;
   localparam int unsigned BW_LOCK = 6;
   localparam int unsigned BW_ACQ = 5;
   localparam logic [4:0] BW_LOW_RD = 5'h00;

   // Reset values
   localparam logic ON_RST = 1'h1;
   localparam logic [7:0] PROG_RST = 8'h66;

   // Crystal and VCO edges waited during a switchover
   localparam int unsigned STASIS_EDGES = 3;

   // Switchover states, gray along the usual path
   typedef enum logic [0:0] {
      SW_RUN = 1'h0,
      SW_HOLD = 1'h1
   } pcg_sw_state_t;

   // Wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [WB_AW-1:0] adr;
      logic [3:0] sel;
      logic [WB_DW-1:0] dat;
   } pcg_wb_req_t;

   // Wishbone answer to the master
   typedef struct packed {
      logic ack;
      logic [WB_DW-1:0] dat;
   } pcg_wb_rsp_t;

endpackage

/* File: hw/pcg_top.sv */
// PLL clock generator control: registers, interlocks, lock flag and base clock selector
// How it works
// - Interrupt enable ignored, zero in manual mode
// - Lock toggle sets flag; flag and enable interrupt
// - Any control register read clears flag
// - Manual mode: flag zero, no interrupt
// - Power bit turns PLL and VCO on/off
// - Reset sets power bit
// - Power cannot clear while VCO selected
// - Select bit picks VCO or crystal, halved
// - Select forced zero if off or range zero
// - Output static during switchover, then clean switch
// - Reset and stop clear select bit
// - Control low nibble reads ones
// - Bandwidth mode bit, reset gives manual
// - Lock indicator in auto mode, else zero
// - Programming register locked while powered
// - Base clock is source divided by two
// - Oscillator and PLL need oscillator enable
// - Interrupt output driven from lock detector
// - Acquisition bit status in auto, kept manual
// - Multiplier upper nibble, zero acts as one
// - Range lower nibble, zero disables PLL
// - Stop mode holds clock and interrupt low
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pcg_top #(
   parameter int unsigned STASIS_EDGES = pcg_pkg::STASIS_EDGES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Register bus
   input wire pcg_pkg::pcg_wb_req_t wb_req_i,
   output var pcg_pkg::pcg_wb_rsp_t wb_rsp_o,
   // Analog loop and oscillator
   input wire logic crystal_clock_i,
   input wire logic vco_clock_i,
   input wire logic lock_raw_i,
   input wire logic acq_raw_i,
   // System integration side
   input wire logic osc_enable_in_i,
   output logic crystal_clock_o,
   output logic base_clock_out_o,
   output logic pll_irq_out_o,
   // Controls to the analog loop
   output logic osc_enable_o,
   output logic pll_enable_o,
   output logic acq_track_select_o,
   output logic auto_bw_o,
   output logic [3:0] feedback_multiplier_o,
   output logic [3:0] vco_range_factor_o
);
   import pcg_pkg::*;

   // Counter holds at most seven edges
   if (STASIS_EDGES < 1 || STASIS_EDGES > 7) begin
      $error("STASIS_EDGES must be 1 to 7");
   end

   localparam logic [2:0] EDGES = 3'(STASIS_EDGES);

   // ---------------- Input synchronisers ----------------
   // Bit order: 0 lock, 1 acquisition, 2 crystal, 3 VCO
   logic [3:0] sync1_ff; // First stage, read only by second
   logic [3:0] sync2_ff; // Safe copies
   logic [3:0] dly_ff; // One cycle older, for edges
   logic [3:0] nxt_sync1;
   logic [3:0] nxt_sync2;
   logic [3:0] nxt_dly;

   // Next values of the synchroniser chain
   always_comb begin
      nxt_sync1 = {vco_clock_i, crystal_clock_i, acq_raw_i, lock_raw_i};
      nxt_sync2 = sync1_ff;
      nxt_dly = sync2_ff;
   end

   // Register the chain
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
         dly_ff <= 4'h0;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         dly_ff <= nxt_dly;
      end
   end

   logic lock_s; // Synchronised lock state
   logic acq_s; // Synchronised acquisition state
   logic lock_edge; // Lock toggled either way
   logic x_rise; // Crystal rising edge seen
   logic v_rise; // VCO rising edge seen
   logic osc_en; // Oscillator enable from system logic

   assign lock_s = sync2_ff[0];
   assign acq_s = sync2_ff[1];
   assign lock_edge = sync2_ff[0] ^ dly_ff[0];
   assign x_rise = sync2_ff[2] & ~dly_ff[2];
   assign v_rise = sync2_ff[3] & ~dly_ff[3];
   // Same-domain logic, so no synchroniser
   assign osc_en = osc_enable_in_i;

   // ---------------- Bus decode ----------------
   logic ack_ff; // Ack, one cycle after the strobe
   logic [WB_DW-1:0] rdat_ff; // Read data, held with ack
   logic nxt_ack;
   logic [WB_DW-1:0] nxt_rdat;
   logic req; // Live request
   logic hit_ctl;
   logic hit_bw;
   logic hit_prog;
   logic wr_ctl; // Write commits at the acked edge
   logic wr_bw;
   logic wr_prog;
   logic rd_ctl; // Control read finishes at this edge
   logic [7:0] wd; // Low byte of write data

   assign req = wb_req_i.cyc & wb_req_i.stb;
   assign hit_ctl = wb_req_i.adr == {IDX_CTL[5:0], 2'h0};
   assign hit_bw = wb_req_i.adr == {IDX_BW[5:0], 2'h0};
   assign hit_prog = wb_req_i.adr == {IDX_PROG[5:0], 2'h0};
   assign wd = wb_req_i.dat[7:0];
   // Only lane 0 holds register bits
   assign wr_ctl = req & ack_ff & wb_req_i.we & wb_req_i.sel[0] & hit_ctl;
   assign wr_bw = req & ack_ff & wb_req_i.we & wb_req_i.sel[0] & hit_bw;
   assign wr_prog = req & ack_ff & wb_req_i.we & wb_req_i.sel[0] & hit_prog;
   // Read-modify-write reads too, so any read clears
   assign rd_ctl = req & ack_ff & ~wb_req_i.we & hit_ctl;

   // ---------------- Register state ----------------
   logic ie_ff; // Lock interrupt enable
   logic flag_ff; // Lock change flag
   logic on_ff; // PLL power on
   logic sel_ff; // VCO clock selected
   logic auto_ff; // Automatic bandwidth mode
   logic acq_man_ff; // Manual acquisition/tracking value
   logic [7:0] prog_ff; // Multiplier and range
   logic irq_ff; // Interrupt output
   logic pll_en_ff; // PLL really running
   logic osc_ff; // Oscillator enable out
   logic nxt_ie;
   logic nxt_flag;
   logic nxt_on;
   logic nxt_sel;
   logic nxt_auto;
   logic nxt_acq_man;
   logic [7:0] nxt_prog;
   logic nxt_irq;
   logic nxt_pll_en;
   logic sel_ok; // VCO may be selected
   logic [7:0] rd_ctl_v; // Read views
   logic [7:0] rd_bw_v;

   assign sel_ok = on_ff & (prog_ff[3:0] != 4'h0) & osc_en;

   // Read views with forced fields
   always_comb begin
      rd_ctl_v = {ie_ff & auto_ff, flag_ff & auto_ff, on_ff, sel_ff, CTL_LOW_RD};
      // Status bits follow the loop only in auto mode
      rd_bw_v = {auto_ff, lock_s & auto_ff, auto_ff ? acq_s : acq_man_ff, BW_LOW_RD};
   end

   // Next values of the software-visible state
   always_comb begin
      nxt_auto = auto_ff;
      if (wr_bw) begin
         nxt_auto = wd[BW_AUTO];
      end
      // Enable ignored and zeroed in manual mode
      nxt_ie = 1'h0;
      if (auto_ff) begin
         nxt_ie = wr_ctl ? wd[CTL_IE] : ie_ff;
      end
      // Clearing power is refused while the select bit has the VCO selected
      nxt_on = on_ff;
      if (wr_ctl && (wd[CTL_ON] || !sel_ff)) begin
         nxt_on = wd[CTL_ON];
      end
      // Uses the old power bit, so power-on and select need two writes
      nxt_sel = sel_ff;
      if (wr_ctl) begin
         nxt_sel = wd[CTL_SEL];
      end
      if (!sel_ok) begin
         nxt_sel = 1'h0;
      end
      // Manual value is kept while in auto mode
      nxt_acq_man = acq_man_ff;
      if (wr_bw && !auto_ff) begin
         nxt_acq_man = wd[BW_ACQ];
      end
      // Programming locked while powered
      nxt_prog = prog_ff;
      if (wr_prog && !on_ff) begin
         nxt_prog = wd;
      end
      // Flag: set wins over the read clear
      nxt_flag = flag_ff;
      if (rd_ctl) begin
         nxt_flag = 1'h0;
      end
      if (lock_edge) begin
         nxt_flag = 1'h1;
      end
      if (!auto_ff) begin
         nxt_flag = 1'h0;
      end
      nxt_irq = flag_ff & ie_ff & auto_ff & osc_en;
      nxt_pll_en = on_ff & (prog_ff[3:0] != 4'h0) & osc_en;
   end

   // Register the software-visible state
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ie_ff <= 1'h0;
         flag_ff <= 1'h0;
         on_ff <= ON_RST;
         sel_ff <= 1'h0;
         auto_ff <= 1'h0;
         acq_man_ff <= 1'h0;
         prog_ff <= PROG_RST;
         irq_ff <= 1'h0;
         pll_en_ff <= 1'h0;
         osc_ff <= 1'h0;
      end else begin
         ie_ff <= nxt_ie;
         flag_ff <= nxt_flag;
         on_ff <= nxt_on;
         sel_ff <= nxt_sel;
         auto_ff <= nxt_auto;
         acq_man_ff <= nxt_acq_man;
         prog_ff <= nxt_prog;
         irq_ff <= nxt_irq;
         pll_en_ff <= nxt_pll_en;
         osc_ff <= osc_en;
      end
   end

   // Next ack and read data; unmapped reads return zero
   always_comb begin
      nxt_ack = req & ~ack_ff;
      nxt_rdat = '0;
      if (hit_ctl) begin
         nxt_rdat[7:0] = rd_ctl_v;
      end else if (hit_bw) begin
         nxt_rdat[7:0] = rd_bw_v;
      end else if (hit_prog) begin
         nxt_rdat[7:0] = prog_ff;
      end
   end

   // Register the bus answer
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ack_ff <= 1'h0;
         rdat_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   // ---------------- Base clock selector ----------------
   pcg_sw_state_t st_ff; // Run or stasis
   logic cur_ff; // Source now driving the divider
   logic [2:0] xcnt_ff; // Crystal edges seen in stasis
   logic [2:0] vcnt_ff; // VCO edges seen in stasis
   logic div_ff; // Divide-by-two output
   logic xclk_ff; // Gated crystal copy
   pcg_sw_state_t nxt_st;
   logic nxt_cur;
   logic [2:0] nxt_xcnt;
   logic [2:0] nxt_vcnt;
   logic nxt_div;
   logic src_rise;

   assign src_rise = cur_ff ? v_rise : x_rise;

   // Next values of the selector
   always_comb begin
      nxt_st = st_ff;
      nxt_cur = cur_ff;
      nxt_xcnt = xcnt_ff;
      nxt_vcnt = vcnt_ff;
      nxt_div = div_ff;
      unique case (st_ff)
         SW_RUN: begin
            if (sel_ff != cur_ff) begin
               nxt_st = SW_HOLD;
               nxt_xcnt = 3'h0;
               nxt_vcnt = 3'h0;
            end else if (src_rise) begin
               nxt_div = ~div_ff;
            end
         end
         SW_HOLD: begin
            // Output frozen; count edges of both sources
            if (x_rise && xcnt_ff != EDGES) begin
               nxt_xcnt = xcnt_ff + 3'h1;
            end
            if (v_rise && vcnt_ff != EDGES) begin
               nxt_vcnt = vcnt_ff + 3'h1;
            end
            // A stopped VCO gives no edges, so it is not waited for
            if (xcnt_ff == EDGES && (vcnt_ff == EDGES || !pll_en_ff)) begin
               nxt_cur = sel_ff;
               nxt_st = SW_RUN;
            end
         end
      endcase
      if (!osc_en) begin
         nxt_div = 1'h0;
      end
   end

   // Register the selector
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= SW_RUN;
         cur_ff <= 1'h0;
         xcnt_ff <= 3'h0;
         vcnt_ff <= 3'h0;
         div_ff <= 1'h0;
         xclk_ff <= 1'h0;
      end else begin
         st_ff <= nxt_st;
         cur_ff <= nxt_cur;
         xcnt_ff <= nxt_xcnt;
         vcnt_ff <= nxt_vcnt;
         div_ff <= nxt_div;
         xclk_ff <= sync2_ff[2] & osc_en;
      end
   end

   // ---------------- Outputs ----------------
   assign wb_rsp_o.ack = ack_ff;
   assign wb_rsp_o.dat = rdat_ff;
   assign crystal_clock_o = xclk_ff;
   assign base_clock_out_o = div_ff;
   assign pll_irq_out_o = irq_ff;
   assign osc_enable_o = osc_ff;
   assign pll_enable_o = pll_en_ff;
   assign acq_track_select_o = acq_man_ff;
   assign auto_bw_o = auto_ff;
   // Zero multiplier acts as one
   assign feedback_multiplier_o = (prog_ff[7:4] == 4'h0) ? 4'h1 : prog_ff[7:4];
   assign vco_range_factor_o = prog_ff[3:0];

   // ---------------- Assertions ----------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   ie_manual_zero_a: assert property (!auto_ff |=> !ie_ff)
      else $error("enable kept in manual mode");
   flag_on_lock_a: assert property (auto_ff && lock_edge |=> flag_ff)
      else $error("lock edge lost");
   read_clears_a: assert property (rd_ctl && !lock_edge |=> !flag_ff)
      else $error("read did not clear flag");
   irq_cause_a: assert property (pll_irq_out_o |-> $past(flag_ff && ie_ff && auto_ff))
      else $error("interrupt without cause");
   power_held_a: assert property (sel_ff |=> on_ff)
      else $error("power cleared with VCO selected");
   sel_forced_a: assert property (!(on_ff && prog_ff[3:0] != 4'h0) |=> !sel_ff)
      else $error("select set while not allowed");
   prog_locked_a: assert property (on_ff |=> $stable(prog_ff))
      else $error("programming changed while powered");
   stasis_hold_a: assert property (st_ff == SW_HOLD && osc_en |=> $stable(base_clock_out_o))
      else $error("base clock moved in stasis");
   stop_low_a: assert property (!osc_en |=> !base_clock_out_o && !pll_irq_out_o && !crystal_clock_o)
      else $error("output active in stop mode");

endmodule
`default_nettype wire

/* File: sim/pcg_loop_model.sv */
// Behavioural analog loop and oscillator facing the clock generator control
`timescale 1ns/100ps
`default_nettype none
module pcg_loop_model (
   // Controls from the block
   input wire logic pll_enable_i,
   // Levels requested by the bench
   input wire logic lock_req_i,
   input wire logic acq_req_i,
   // Loop outputs
   output logic crystal_clock_o,
   output logic vco_clock_o,
   output logic lock_raw_o,
   output logic acq_raw_o
);
   // Crystal runs free at 2.5 MHz, well under the sampling limit
   initial crystal_clock_o = 1'b0;
   always #200 crystal_clock_o = ~crystal_clock_o;
   // VCO runs only while the loop is enabled; a stopped VCO sits low
   initial vco_clock_o = 1'b0;
   always #120 vco_clock_o = pll_enable_i ? ~vco_clock_o : 1'b0;
   // Lock and acquisition states follow the bench directly
   assign lock_raw_o = lock_req_i;
   assign acq_raw_o = acq_req_i;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the PLL clock generator control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pcg_pkg::*;
   // Clock, reset and bus
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   pcg_wb_req_t req = '0;
   pcg_wb_rsp_t rsp;
   // Loop and system side
   logic osc_en = 1'b1;
   logic lock_req = 1'b0;
   logic acq_req = 1'b0;
   logic xclk, vclk, lock_raw, acq_raw, xclk_o, base, irq, osc_o, pll_en, acq_o, auto_o;
   logic [3:0] mult, rng;
   // Tallies
   int err_count = 0;
   int checks = 0;
   int base_rises = 0;
   int xclk_rises = 0;
   logic [31:0] rd;

   // 25 MHz system clock
   always #20 ref_clk = ~ref_clk;

   pcg_top uut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .wb_req_i(req), .wb_rsp_o(rsp),
      .crystal_clock_i(xclk), .vco_clock_i(vclk), .lock_raw_i(lock_raw), .acq_raw_i(acq_raw),
      .osc_enable_in_i(osc_en), .crystal_clock_o(xclk_o), .base_clock_out_o(base),
      .pll_irq_out_o(irq), .osc_enable_o(osc_o), .pll_enable_o(pll_en),
      .acq_track_select_o(acq_o), .auto_bw_o(auto_o), .feedback_multiplier_o(mult),
      .vco_range_factor_o(rng));

   pcg_loop_model loop (.pll_enable_i(pll_en), .lock_req_i(lock_req), .acq_req_i(acq_req),
      .crystal_clock_o(xclk), .vco_clock_o(vclk), .lock_raw_o(lock_raw), .acq_raw_o(acq_raw));

   // Edge tallies of the clock outputs
   always @(posedge base) base_rises++;
   always @(posedge xclk_o) xclk_rises++;

   // Exact compare; unknowns never match
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Classic cycle: request held until ack is sampled high at a rising edge, data taken and request
   // released at that same edge, so the write commits exactly once
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {idx[5:0], 2'h0}, sel: 4'hf, dat: {24'h00_0000, wd}};
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp.ack !== 1'h1 && n < 20);
      if (n >= 20) check("ack", 1, 0);
      rd = rsp.dat;
      req <= '0;
   endtask

   // Read a register and compare the whole data word
   task automatic rc(input string name, input logic [7:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      check(name, {24'h00_0000, exp}, rd);
   endtask

   // Let a number of cycles pass, ending mid-cycle
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Base clock rises over 400 cycles, one edge of slack for sampling jitter
   task automatic count_base(input int exp);
      base_rises = 0;
      cyc(400);
      checks++;
      if (base_rises < exp - 1 || base_rises > exp + 1) begin
         err_count++;
         $display("unexpected base clock rises: expected %0d, seen %0d", exp, base_rises);
      end
   endtask

   // Verdict and end of run
   task automatic give_verdict();
      $display("checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Tests take about 1500 cycles; this 10000-cycle limit cuts a hang short
   initial begin
      #400000;
      err_count++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // Reset values and an unmapped place
      rc("ctl reset", IDX_CTL, 8'h2f);
      rc("bw reset", IDX_BW, 8'h00);
      rc("prog reset", IDX_PROG, 8'h66);
      rc("unmapped", 8'h1f, 8'h00);
      check("pll enable", 1, pll_en);
      check("osc out", 1, osc_o);
      check("mult reset", 6, mult);
      check("range reset", 6, rng);
      // Manual mode: enable refused, lock edges hidden, program locked while on
      wb(1'b1, IDX_CTL, 8'ha0);
      lock_req <= 1'b1;
      cyc(10);
      rc("ctl manual", IDX_CTL, 8'h2f);
      check("irq manual", 0, irq);
      wb(1'b1, IDX_PROG, 8'h12);
      rc("prog on", IDX_PROG, 8'h66);
      wb(1'b1, IDX_BW, 8'h20);
      rc("bw manual acq", IDX_BW, 8'h20);
      check("acq out", 1, acq_o);
      wb(1'b1, IDX_BW, 8'h00);
      // Power off, program zeros, range zero blocks the VCO
      wb(1'b1, IDX_CTL, 8'h00);
      rc("ctl off", IDX_CTL, 8'h0f);
      check("pll off", 0, pll_en);
      wb(1'b1, IDX_PROG, 8'h00);
      rc("prog zero", IDX_PROG, 8'h00);
      check("mult zero", 1, mult);
      wb(1'b1, IDX_CTL, 8'h20);
      wb(1'b1, IDX_CTL, 8'h30);
      rc("ctl range zero", IDX_CTL, 8'h2f);
      check("pll range zero", 0, pll_en);
      // From off: a joint write may not select, the second write does
      wb(1'b1, IDX_CTL, 8'h00);
      wb(1'b1, IDX_PROG, 8'h66);
      wb(1'b1, IDX_CTL, 8'h30);
      rc("ctl one write", IDX_CTL, 8'h2f);
      wb(1'b1, IDX_CTL, 8'h30);
      rc("ctl vco", IDX_CTL, 8'h3f);
      cyc(50);
      count_base(33);
      // Keep the VCO selected and try to power down
      wb(1'b1, IDX_CTL, 8'h10);
      rc("ctl keep on", IDX_CTL, 8'h3f);
      // Auto mode: lock status, flag, interrupt, read clear
      // Manual acquisition value written as one on the way into auto, then hidden by status
      wb(1'b1, IDX_BW, 8'ha0);
      rc("bw auto", IDX_BW, 8'hc0);
      check("auto out", 1, auto_o);
      wb(1'b1, IDX_CTL, 8'hb0);
      rc("ctl ie", IDX_CTL, 8'hbf);
      check("irq idle", 0, irq);
      lock_req <= 1'b0;
      cyc(10);
      check("irq lock lost", 1, irq);
      rc("ctl flag", IDX_CTL, 8'hff);
      rc("ctl cleared", IDX_CTL, 8'hbf);
      cyc(3);
      check("irq cleared", 0, irq);
      @(posedge ref_clk);
      acq_req <= 1'h1;
      cyc(10);
      rc("bw auto acq", IDX_BW, 8'ha0);
      wb(1'b1, IDX_BW, 8'h00);
      rc("bw manual back", IDX_BW, 8'h20);
      check("acq restored", 1, acq_o);
      rc("ctl manual back", IDX_CTL, 8'h3f);
      // Stop mode holds outputs low and drops the VCO select
      osc_en <= 1'b0;
      cyc(4);
      xclk_rises = 0;
      count_base(0);
      check("crystal out stop", 0, xclk_rises);
      check("irq stop", 0, irq);
      check("osc out stop", 0, osc_o);
      check("pll stop", 0, pll_en);
      @(posedge ref_clk);
      osc_en <= 1'h1;
      cyc(4);
      rc("ctl after stop", IDX_CTL, 8'h2f);
      cyc(50);
      count_base(20);
      give_verdict();
   end
endmodule
`default_nettype wire
